//--- slfp_map.svh
// Register offsets, field positions and reset values of the framing registers
`ifndef SLFP_MAP_SVH
`define SLFP_MAP_SVH

// ****************************************************************
// Offsets on the register port
// ****************************************************************
`define SLFP_OFS_OCTETS   12'h58c
`define SLFP_OFS_FRAMES   12'h58d
`define SLFP_OFS_CONVS    12'h58e
`define SLFP_OFS_CSRES    12'h58f

// ****************************************************************
// Field positions
// ****************************************************************
`define SLFP_FRAMES_MSB   4
`define SLFP_CS_MSB       7
`define SLFP_CS_LSB       6
`define SLFP_RES_MSB      4

// ****************************************************************
// Reset values
// ****************************************************************
`define SLFP_RST_OCTETS   8'h00
`define SLFP_RST_FRAMES   5'h1f
`define SLFP_RST_CONVS    8'h01
`define SLFP_RST_CS       2'h0
`define SLFP_RST_RES      5'h0f

`endif

//--- slfp_pkg.sv
// Types shared by the framing register bank
package slfp_pkg;
  typedef logic [7:0]  slfp_byte_t;
  typedef logic [11:0] slfp_addr_t;
  typedef enum logic [1:0] {
    SLFP_CS_NONE,
    SLFP_CS_BIT2,
    SLFP_CS_BIT21,
    SLFP_CS_ALL
  } slfp_cs_t;
endpackage

//--- slfp_decode.sv
// Decoder from stored field codes to framing counts
`timescale 1ns/1ps
`include "slfp_map.svh"
module slfp_decode
  import slfp_pkg::*;
(
  // Stored codes
  input  wire logic [7:0] octets_code,
  input  wire logic [4:0] frames_code,
  input  wire logic [7:0] convs_code,
  input  wire logic [1:0] cs_code,
  input  wire logic [4:0] res_code,
  // Decoded counts
  output logic      [8:0] octets,
  output logic      [5:0] frames,
  output logic      [3:0] convs,
  output logic            convs_ok,
  output logic      [2:0] cs_keep,
  output logic      [5:0] res_bits,
  output logic            res_ok,
  output logic            fk_ok
);
  logic [14:0] fk;

  always_comb begin
    octets = {1'b0, octets_code} + 9'h001;
    frames = {1'b0, frames_code} + 6'h01;
    fk     = 15'(octets) * 15'(frames);
    fk_ok  = (fk[1:0] == 2'h0);
    convs_ok = 1'b1;
    unique case (convs_code)
      8'h00:   convs = 4'h1;
      8'h01:   convs = 4'h2;
      8'h03:   convs = 4'h4;
      8'h07:   convs = 4'h8;
      default: begin
        convs    = 4'h2;
        convs_ok = 1'b0;
      end
    endcase
    unique case (slfp_cs_t'(cs_code))
      SLFP_CS_NONE:  cs_keep = 3'h0;
      SLFP_CS_BIT2:  cs_keep = 3'h4;
      SLFP_CS_BIT21: cs_keep = 3'h6;
      SLFP_CS_ALL:   cs_keep = 3'h7;
    endcase
    res_bits = {1'b0, res_code} + 6'h01;
    res_ok   = (res_code >= 5'h06) && (res_code <= 5'h0f);
  end
endmodule // slfp_decode

//--- slfp_regs.sv
// Framing parameter register bank of the serial transmit link
`timescale 1ns/1ps
`include "slfp_map.svh"
// Overview of operation
// - Octets per frame is field plus one; resets to one octet.
// - Frames per multiframe is 5-bit field plus one; resets to 32.
// - Converter codes 0,1,3,7 give 1,2,4,8 converters; reset gives two.
// - Control-bit code picks none, bit 2, bits 2-1, or all three.
// - Resolution field is bits minus one, 7 to 16 bits; resets 0xF.
// - Resolution codes continue to 14, 15 and 16 bits.
module slfp_regs
  import slfp_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Register port
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire slfp_addr_t reg_addr,
  input  wire slfp_byte_t reg_wdata,
  output slfp_byte_t      reg_rdata_q,
  // Framing parameters to the framer
  output logic      [8:0] octets_per_frame_q,
  output logic      [5:0] frames_per_multiframe_q,
  output logic      [3:0] converter_count_q,
  output logic      [2:0] control_bits_keep_q,
  output logic      [1:0] control_bits_count_q,
  output logic      [5:0] resolution_bits_q,
  output logic            config_error_q
);
  // ****************************************************************
  // Stored fields
  // ****************************************************************
  slfp_byte_t octets_per_frame_field;
  logic [4:0] frames_per_multiframe_field;
  slfp_byte_t converter_count_field;
  logic [1:0] cs_field;
  logic [4:0] res_field;

  logic [8:0] octets_d;
  logic [5:0] frames_d;
  logic [3:0] convs_d;
  logic [2:0] keep_d;
  logic [5:0] res_d;
  logic       convs_ok;
  logic       res_ok;
  logic       fk_ok;
  slfp_byte_t rdata_d;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      octets_per_frame_field      <= `SLFP_RST_OCTETS;
      frames_per_multiframe_field <= `SLFP_RST_FRAMES;
      converter_count_field       <= `SLFP_RST_CONVS;
      cs_field                    <= `SLFP_RST_CS;
      res_field                   <= `SLFP_RST_RES;
    end else if (reg_wr) begin
      unique case (reg_addr)
        `SLFP_OFS_OCTETS: octets_per_frame_field <= reg_wdata;
        `SLFP_OFS_FRAMES: frames_per_multiframe_field <=
          reg_wdata[`SLFP_FRAMES_MSB:0];
        `SLFP_OFS_CONVS:  converter_count_field <= reg_wdata;
        `SLFP_OFS_CSRES: begin
          cs_field  <= reg_wdata[`SLFP_CS_MSB:`SLFP_CS_LSB];
          res_field <= reg_wdata[`SLFP_RES_MSB:0];
        end
        default: ;
      endcase
    end
  end

  // ****************************************************************
  // Decode and read-back
  // ****************************************************************
  slfp_decode u_decode (
    .octets_code (octets_per_frame_field),
    .frames_code (frames_per_multiframe_field),
    .convs_code  (converter_count_field),
    .cs_code     (cs_field),
    .res_code    (res_field),
    .octets      (octets_d),
    .frames      (frames_d),
    .convs       (convs_d),
    .convs_ok    (convs_ok),
    .cs_keep     (keep_d),
    .res_bits    (res_d),
    .res_ok      (res_ok),
    .fk_ok       (fk_ok)
  );

  always_comb begin
    unique case (reg_addr)
      `SLFP_OFS_OCTETS: rdata_d = octets_per_frame_field;
      `SLFP_OFS_FRAMES: rdata_d = {3'h0, frames_per_multiframe_field};
      `SLFP_OFS_CONVS:  rdata_d = converter_count_field;
      `SLFP_OFS_CSRES:  rdata_d = {cs_field, 1'b0, res_field};
      default:          rdata_d = 8'h00;
    endcase
  end

  // Read data held between reads so software sees a stable byte
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata_q <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata_q <= rdata_d;
    end
  end

  // ****************************************************************
  // Registered parameters to the framer
  // ****************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      octets_per_frame_q      <= 9'h001;
      frames_per_multiframe_q <= 6'h20;
      converter_count_q       <= 4'h2;
      control_bits_keep_q     <= 3'h0;
      control_bits_count_q    <= 2'h0;
      resolution_bits_q       <= 6'h10;
      config_error_q          <= 1'b0;
    end else begin
      octets_per_frame_q      <= octets_d;
      frames_per_multiframe_q <= frames_d;
      converter_count_q       <= convs_d;
      control_bits_keep_q     <= keep_d;
      control_bits_count_q    <= cs_field;
      resolution_bits_q       <= res_d;
      // Flags settings the far end cannot accept; not enforced
      config_error_q <= !fk_ok || !convs_ok || !res_ok;
    end
  end
endmodule // slfp_regs

//--- slfp_regs_assertions.sv
// Concurrent checks of the framing register bank
`timescale 1ns/1ps
module slfp_regs_chk
  import slfp_pkg::*;
(
  input wire logic       clock,
  input wire logic       rst,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire slfp_addr_t reg_addr,
  input wire slfp_byte_t reg_wdata,
  input wire slfp_byte_t reg_rdata_q,
  input wire logic [8:0] octets_per_frame_q,
  input wire logic [5:0] frames_per_multiframe_q,
  input wire logic [3:0] converter_count_q,
  input wire logic [2:0] control_bits_keep_q,
  input wire logic [1:0] control_bits_count_q,
  input wire logic [5:0] resolution_bits_q
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // Write data two edges back, lined up with the decoded outputs
  slfp_byte_t d1, d2;
  always_ff @(posedge clock) begin
    d1 <= reg_wdata;
    d2 <= d1;
  end
  AST_OCTETS: assert property (reg_wr && reg_addr == 12'h58c |-> ##2
    octets_per_frame_q == {1'b0, d2} + 9'h1) else $error("octets");
  AST_FRAMES: assert property (reg_wr && reg_addr == 12'h58d |-> ##2
    frames_per_multiframe_q == {1'b0, d2[4:0]} + 6'h1) else $error("frames");
  AST_CONVS: assert property (reg_wr && reg_addr == 12'h58e |-> ##2
    converter_count_q == (d2 == 8'h00 ? 4'h1 : d2 == 8'h03 ? 4'h4 :
    d2 == 8'h07 ? 4'h8 : 4'h2)) else $error("converters");
  AST_CSKEEP: assert property (reg_wr && reg_addr == 12'h58f |-> ##2
    control_bits_count_q == d2[7:6] && control_bits_keep_q ==
    {d2[7:6] != 2'h0, d2[7], d2[7:6] == 2'h3}) else $error("control bits");
  AST_RES: assert property (reg_wr && reg_addr == 12'h58f |-> ##2
    resolution_bits_q == {1'b0, d2[4:0]} + 6'h1) else $error("resolution");
  AST_RSVD_K: assert property (reg_rd && reg_addr == 12'h58d |=>
    reg_rdata_q[7:5] == 3'h0) else $error("reserved bits");
  AST_RSVD_N: assert property (reg_rd && reg_addr == 12'h58f |=>
    !reg_rdata_q[5]) else $error("reserved bit");
  AST_UNMAP: assert property (reg_rd && !(reg_addr inside {[12'h58c:12'h58f]})
    |=> reg_rdata_q == 8'h00) else $error("unmapped read");
endmodule // slfp_regs_chk
bind slfp_regs slfp_regs_chk u_chk(.clock(clock), .rst(rst), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata_q(reg_rdata_q), .octets_per_frame_q(octets_per_frame_q),
  .frames_per_multiframe_q(frames_per_multiframe_q),
  .converter_count_q(converter_count_q),
  .control_bits_keep_q(control_bits_keep_q),
  .control_bits_count_q(control_bits_count_q),
  .resolution_bits_q(resolution_bits_q));

//--- slfp_sw_model.sv
// Software model that drives the register port
`timescale 1ns/1ps
module slfp_sw_model
  import slfp_pkg::*;
(
  input  wire logic       clock,
  output logic            reg_wr,
  output logic            reg_rd,
  output slfp_addr_t      reg_addr,
  output slfp_byte_t      reg_wdata,
  input  wire slfp_byte_t reg_rdata_q
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 8'h00;
  end
  task acc(input logic w, input slfp_addr_t a, input slfp_byte_t d,
           output slfp_byte_t q);
    @(posedge clock);
    #1;
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = ~d; // Stale data must never look valid
    q = reg_rdata_q;
  endtask
endmodule // slfp_sw_model

//--- tb_slfp_regs.sv
// Self-checking bench of the framing register bank
`timescale 1ns/1ps
module tb_slfp_regs;
  import slfp_pkg::*;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       wr, rd, err;
  slfp_addr_t ad;
  slfp_byte_t wd, rdq, q;
  logic [8:0] opf;
  logic [5:0] fpm, rb;
  logic [3:0] cc;
  logic [2:0] kp;
  logic [1:0] cs;
  int         miscompares = 0;
  int         num_checks = 0;
  int         cycles = 0;
  slfp_byte_t fc[7] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h07, 8'h0f};
  always #10 clock = ~clock;
  slfp_regs u_dut(.clock(clock), .rst(rst), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(ad), .reg_wdata(wd), .reg_rdata_q(rdq),
    .octets_per_frame_q(opf), .frames_per_multiframe_q(fpm),
    .converter_count_q(cc), .control_bits_keep_q(kp),
    .control_bits_count_q(cs), .resolution_bits_q(rb),
    .config_error_q(err));
  slfp_sw_model u_sw(.clock(clock), .reg_wr(wr), .reg_rd(rd),
    .reg_addr(ad), .reg_wdata(wd), .reg_rdata_q(rdq));
  task chk(input string n, input logic [8:0] s, input logic [8:0] e);
    num_checks++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task rd8(input slfp_addr_t a, input slfp_byte_t e);
    u_sw.acc(1'b0, a, 8'h00, q);
    chk("rdata", {1'b0, q}, {1'b0, e});
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      end_of_test;
    end
  end
  initial begin
    repeat (10) @(posedge clock);
    #1 rst = 1'b0;
    chk("f", opf, 9'h1);
    chk("k", {3'h0, fpm}, 9'h20);
    chk("m", {5'h0, cc}, 9'h2);
    chk("n", {3'h0, rb}, 9'h10);
    chk("cs", {7'h0, cs}, 9'h0);
    chk("err", {8'h0, err}, 9'h0);
    rd8(12'h58c, 8'h00);
    rd8(12'h58d, 8'h1f);
    rd8(12'h58e, 8'h01);
    rd8(12'h58f, 8'h0f);
    foreach (fc[i]) begin
      u_sw.acc(1'b1, 12'h58c, fc[i], q);
      rd8(12'h58c, fc[i]);
      chk("f", opf, {1'b0, fc[i]} + 9'h1);
    end
    u_sw.acc(1'b1, 12'h58d, 8'hff, q);
    rd8(12'h58d, 8'h1f);
    u_sw.acc(1'b1, 12'h58d, 8'h03, q);
    rd8(12'h58d, 8'h03);
    chk("k", {3'h0, fpm}, 9'h4);
    for (int i = 0; i < 4; i++) begin
      u_sw.acc(1'b1, 12'h58e, 8'((1 << i) - 1), q);
      rd8(12'h58e, 8'((1 << i) - 1));
      chk("m", {5'h0, cc}, 9'(1 << i));
      chk("err", {8'h0, err}, 9'h0);
    end
    // Unsupported converter code stays stored but raises the flag
    u_sw.acc(1'b1, 12'h58e, 8'h02, q);
    rd8(12'h58e, 8'h02);
    chk("m", {5'h0, cc}, 9'h2);
    chk("err", {8'h0, err}, 9'h1);
    u_sw.acc(1'b1, 12'h58e, 8'h07, q);
    rd8(12'h58e, 8'h07);
    chk("m", {5'h0, cc}, 9'h8);
    chk("err", {8'h0, err}, 9'h0);
    for (int n = 6; n < 16; n++) begin
      u_sw.acc(1'b1, 12'h58f, {n[1:0], 1'b1, n[4:0]}, q);
      rd8(12'h58f, {n[1:0], 1'b0, n[4:0]});
      chk("n", {3'h0, rb}, 9'(n + 1));
      chk("keep", {6'h0, kp}, {6'h0, n[1:0] != 0, n[1], n[1:0] == 3});
      chk("cs", {7'h0, cs}, {7'h0, n[1:0]});
      chk("err", {8'h0, err}, 9'h0);
    end
    u_sw.acc(1'b1, 12'h58b, 8'h5a, q);
    rd8(12'h58b, 8'h00);
    rd8(12'h58c, 8'h0f);
    end_of_test;
  end
endmodule // tb_slfp_regs
